// ==== hdl/tmr_ch4_pkg.sv ====
// Package: register map, field layout and types for the channel 4 pin block
package tmr_ch4_pkg;
	localparam int unsigned ADDR_W         = 8;
	localparam int unsigned CNT_W          = 16;
	localparam logic [7:0]  OFS_IO_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_GRA        = 8'h04;
	localparam logic [7:0]  OFS_COUNTER    = 8'h08;
	localparam logic [7:0]  OFS_STATUS     = 8'h0c;
	localparam logic [7:0]  OFS_RUN_CTRL   = 8'h10;
	localparam int unsigned IO_SEL_POS     = 0;
	localparam int unsigned IO_HI_POS      = 4;
	localparam logic [7:0]  IO_CTRL_RST    = 8'h00;
	localparam logic [CNT_W-1:0] GRA_RST   = 16'hffff;
	localparam logic [CNT_W-1:0] CNT_RST   = 16'h0000;
	localparam int unsigned ST_PIN_POS     = 0;
	localparam int unsigned ST_CAP_POS     = 1;
	localparam int unsigned ST_MATCH_POS   = 2;
	localparam int unsigned ST_WRITTEN_POS = 3;
	localparam logic [1:0]  RESP_OKAY      = 2'b00;
	localparam logic [1:0]  RESP_SLVERR    = 2'b10;

	typedef struct packed {
		logic       inp;
		logic       init_high;
		logic [1:0] act;
	} io_sel_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0]       data;
		logic [3:0]        strb;
	} wr_req_t;
endpackage

// ==== hdl/tmr_ch4_pin_io.sv ====
// Channel 4 register A compare/capture pin control with AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
module tmr_ch4_pin_io
	import tmr_ch4_pkg::*;
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output var  logic              s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output var  logic              s_axi_wready,
	output var  logic [1:0]        s_axi_bresp,
	output var  logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output var  logic              s_axi_arready,
	output var  logic [31:0]       s_axi_rdata,
	output var  logic [1:0]        s_axi_rresp,
	output var  logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Channel pin (two-way)
	input  wire logic              ch4_pin_a_in,
	output var  logic              ch4_pin_a_out,
	output var  logic              ch4_pin_a_oe
);
	logic              aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
	wr_req_t           wreq_r, wreq_nxt;
	logic              bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0]       rdata_r, rdata_nxt;
	logic [7:0]        io_ctrl_r, io_ctrl_nxt;
	logic [CNT_W-1:0]  gra_r, gra_nxt, cnt_r, cnt_nxt;
	logic              run_r, run_nxt, written_r, written_nxt;
	logic              pin_r, pin_nxt, oe_r, oe_nxt;
	logic              cap_flag_r, cap_flag_nxt, match_flag_r, match_flag_nxt;
	logic              sync1_r, sync2_r, prev_r;
	logic              do_write, match, rise, fall, cap_ev;
	logic              io_wr, gra_wr, cnt_wr, st_wr, run_wr;
	io_sel_t           sel;

	assign sel    = io_sel_t'(io_ctrl_r[IO_SEL_POS +: 4]);
	assign match  = (cnt_r == gra_r);
	assign rise   = sync2_r & ~prev_r;
	assign fall   = ~sync2_r & prev_r;

	always_comb begin
		cap_ev = 1'b0;
		if (sel.inp) begin
			if (sel.act[1])
				cap_ev = rise | fall;
			else if (sel.act[0])
				cap_ev = fall;
			else
				cap_ev = rise;
		end
	end

	// Write path: address and data taken in either order
	assign do_write = aw_hold_r & w_hold_r & ~bvalid_r;
	assign io_wr    = do_write && wreq_r.addr == OFS_IO_CTRL && wreq_r.strb[0];
	assign gra_wr   = do_write && wreq_r.addr == OFS_GRA;
	assign cnt_wr   = do_write && wreq_r.addr == OFS_COUNTER;
	assign st_wr    = do_write && wreq_r.addr == OFS_STATUS && wreq_r.strb[0];
	assign run_wr   = do_write && wreq_r.addr == OFS_RUN_CTRL && wreq_r.strb[0];

	always_comb begin
		aw_hold_nxt = aw_hold_r;
		w_hold_nxt  = w_hold_r;
		wreq_nxt    = wreq_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		if (s_axi_awvalid && !aw_hold_r) begin
			aw_hold_nxt   = 1'b1;
			wreq_nxt.addr = {s_axi_awaddr[ADDR_W-1:2], 2'b00};
		end
		if (s_axi_wvalid && !w_hold_r) begin
			w_hold_nxt    = 1'b1;
			wreq_nxt.data = s_axi_wdata;
			wreq_nxt.strb = s_axi_wstrb;
		end
		if (do_write) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = (io_wr | gra_wr | cnt_wr | st_wr | run_wr
				| wreq_r.addr == OFS_IO_CTRL | wreq_r.addr == OFS_STATUS
				| wreq_r.addr == OFS_RUN_CTRL) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
	end

	// Read path: one-cycle registered answer
	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (s_axi_arvalid && !rvalid_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = RESP_OKAY;
			unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
				OFS_IO_CTRL:  rdata_nxt = {24'h000000, io_ctrl_r};
				OFS_GRA:      rdata_nxt = {16'h0000, gra_r};
				OFS_COUNTER:  rdata_nxt = {16'h0000, cnt_r};
				OFS_STATUS:   rdata_nxt = {28'h0000000, written_r, match_flag_r, cap_flag_r, pin_r};
				OFS_RUN_CTRL: rdata_nxt = {31'h00000000, run_r};
				default: begin
					rdata_nxt = 32'h00000000;
					rresp_nxt = RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	// Timer core
	always_comb begin
		io_ctrl_nxt    = io_ctrl_r;
		gra_nxt        = gra_r;
		cnt_nxt        = cnt_r;
		run_nxt        = run_r;
		written_nxt    = written_r;
		pin_nxt        = pin_r;
		oe_nxt         = oe_r;
		cap_flag_nxt   = cap_flag_r;
		match_flag_nxt = match_flag_r;
		if (run_r)
			cnt_nxt = cnt_r + 16'h0001;
		if (cnt_wr)
			cnt_nxt = wreq_r.data[CNT_W-1:0];
		if (run_wr)
			run_nxt = wreq_r.data[0];
		if (gra_wr)
			gra_nxt = wreq_r.data[CNT_W-1:0];
		// Flags: clear by writing 1; a same-cycle event wins
		if (st_wr) begin
			if (wreq_r.data[ST_CAP_POS])
				cap_flag_nxt = 1'b0;
			if (wreq_r.data[ST_MATCH_POS])
				match_flag_nxt = 1'b0;
		end
		if (!sel.inp) begin
			oe_nxt = 1'b1;
			if (match && sel.act != 2'b00) begin
				match_flag_nxt = 1'b1;
				unique case (sel.act)
					2'b01:   pin_nxt = 1'b0;
					2'b10:   pin_nxt = 1'b1;
					default: pin_nxt = ~pin_r;
				endcase
			end
		end else begin
			oe_nxt = 1'b0;
			if (cap_ev) begin
				gra_nxt      = cnt_r;
				cap_flag_nxt = 1'b1;
			end
		end
		if (io_wr) begin
			io_ctrl_nxt = wreq_r.data[7:0];
			written_nxt = 1'b1;
			// New output setting forces the initial level; retain codes keep the pin
			if (!wreq_r.data[3] && wreq_r.data[1:0] != 2'b00)
				pin_nxt = wreq_r.data[2];
			else if (!wreq_r.data[3] && wreq_r.data[1:0] == 2'b00)
				pin_nxt = pin_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r    <= 1'b0;
			w_hold_r     <= 1'b0;
			wreq_r       <= '0;
			bvalid_r     <= 1'b0;
			bresp_r      <= RESP_OKAY;
			rvalid_r     <= 1'b0;
			rdata_r      <= 32'h00000000;
			rresp_r      <= RESP_OKAY;
			io_ctrl_r    <= IO_CTRL_RST;
			gra_r        <= GRA_RST;
			cnt_r        <= CNT_RST;
			run_r        <= 1'b0;
			written_r    <= 1'b0;
			pin_r        <= 1'b0;
			oe_r         <= 1'b1;
			cap_flag_r   <= 1'b0;
			match_flag_r <= 1'b0;
			sync1_r      <= 1'b0;
			sync2_r      <= 1'b0;
			prev_r       <= 1'b0;
		end else begin
			aw_hold_r    <= aw_hold_nxt;
			w_hold_r     <= w_hold_nxt;
			wreq_r       <= wreq_nxt;
			bvalid_r     <= bvalid_nxt;
			bresp_r      <= bresp_nxt;
			rvalid_r     <= rvalid_nxt;
			rdata_r      <= rdata_nxt;
			rresp_r      <= rresp_nxt;
			io_ctrl_r    <= io_ctrl_nxt;
			gra_r        <= gra_nxt;
			cnt_r        <= cnt_nxt;
			run_r        <= run_nxt;
			written_r    <= written_nxt;
			pin_r        <= pin_nxt;
			oe_r         <= oe_nxt;
			cap_flag_r   <= cap_flag_nxt;
			match_flag_r <= match_flag_nxt;
			sync1_r      <= ch4_pin_a_in;
			sync2_r      <= sync1_r;
			prev_r       <= sync2_r;
		end
	end

	assign s_axi_awready = ~aw_hold_r;
	assign s_axi_wready  = ~w_hold_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign ch4_pin_a_out = pin_r;
	assign ch4_pin_a_oe  = oe_r;
endmodule
`default_nettype wire

// ==== bench/pin_src_model.sv ====
// Far-side signal source on the channel 4 pin
`timescale 1ns/100ps
`default_nettype none
module pin_src_model (
	// Block side
	input  wire logic oe,
	input  wire logic drv,
	// Source side
	input  wire logic lvl,
	output var  logic pin
);
	// Source drives only while the block has let go of the pin
	always_comb pin = oe ? drv : lvl;
endmodule
`default_nettype wire

// ==== bench/tmr_ch4_checker.sv ====
// Checker: bus handshakes and pin drive of the channel 4 block
`timescale 1ns/100ps
`default_nettype none
module tmr_ch4_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pin
	input wire logic ch4_pin_a_out,
	input wire logic ch4_pin_a_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_reset_pin: assert property (disable iff (1'b0) !aresetn |=> !ch4_pin_a_out && ch4_pin_a_oe)
		else $error("pin not low and driven in reset");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[2:3] s_axi_bvalid)
		else $error("write answer late");
	a_wr_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("write answer not retired");
	a_wr_busy: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready) && $past(!s_axi_wready))
		else $error("write answered without address and data held");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_rd_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read answer not retired");
	a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	a_oe_by_write: assert property ($changed(ch4_pin_a_oe) |-> $past(s_axi_bvalid))
		else $error("pin drive changed without a write");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_release: cover property ($fell(ch4_pin_a_oe));
	c_match: cover property ($changed(ch4_pin_a_out) && ch4_pin_a_oe && !s_axi_bvalid);
endmodule
bind tmr_ch4_pin_io tmr_ch4_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.ch4_pin_a_out, .ch4_pin_a_oe);
`default_nettype wire

// ==== bench/tb.sv ====
// Testbench: registers, compare output and input capture of channel 4
`timescale 1ns/100ps
`default_nettype none
module tb;
	import tmr_ch4_pkg::*;
	logic aclk, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, lvl = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rd;
	logic [1:0] br, rr, wresp;
	logic awrdy, wrdy, bv, arrdy, rv, po, oe, pin;
	int num_errors = 0, tests_run = 0, cyc = 0;
	tmr_ch4_pin_io u_dut (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arrdy),
		.s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .ch4_pin_a_in(pin),
		.ch4_pin_a_out(po), .ch4_pin_a_oe(oe));
	pin_src_model u_pin (.oe, .drv(po), .lvl, .pin);
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			end_of_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		do begin
			@(posedge aclk);
			if (awrdy) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
		end while (!bv);
		wresp = br;
		bre <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rdt(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		do begin
			@(posedge aclk);
			if (arrdy) arv <= 1'b0;
		end while (!rv);
		d = rd;
		r = rr;
		rre <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic t_bus();
		logic [31:0] d;
		logic [1:0] r;
		chk("pin_out", 32'h0, 32'(po));
		chk("pin_oe", 32'h1, 32'(oe));
		rdt(OFS_IO_CTRL, d, r);
		chk("io_ctrl", 32'(IO_CTRL_RST), d);
		chk("io_ctrl_resp", 32'(RESP_OKAY), 32'(r));
		rdt(8'h20, d, r);
		chk("unmapped", 32'(RESP_SLVERR), 32'(r));
		wr(OFS_GRA, 32'(GRA_RST));
		chk("wr_resp", 32'(RESP_OKAY), 32'(wresp));
		wr(8'h20, 32'h0);
		chk("wr_unmapped", 32'(RESP_SLVERR), 32'(wresp));
	endtask
	task automatic t_compare();
		logic [3:0] c;
		logic e;
		for (int i = 1; i < 8; i++) begin
			if (i == 4) continue;
			c = 4'(i);
			e = (c[1:0] == 2'h1) ? 1'b0 : (c[1:0] == 2'h2) ? 1'b1 : ~c[2];
			wr(OFS_RUN_CTRL, 32'h0);
			wr(OFS_COUNTER, 32'h0);
			wr(OFS_GRA, 32'h5);
			wr(OFS_IO_CTRL, 32'(c));
			chk("init_level", 32'(c[2]), 32'(po));
			wr(OFS_RUN_CTRL, 32'h1);
			repeat (20) @(posedge aclk);
			chk("match_level", 32'(e), 32'(po));
		end
		// Pin high first, so a retain code that drives low shows up
		wr(OFS_IO_CTRL, 32'h6);
		wr(OFS_IO_CTRL, 32'h4);
		repeat (20) @(posedge aclk);
		chk("retained", 32'h1, 32'(po));
		wr(OFS_IO_CTRL, 32'h0);
		repeat (20) @(posedge aclk);
		chk("retained_zero", 32'h1, 32'(po));
	endtask
	task automatic t_recovery();
		wr(OFS_RUN_CTRL, 32'h0);
		wr(OFS_IO_CTRL, 32'h1);
		chk("recover_low", 32'h0, 32'(po));
		chk("recover_oe", 32'h1, 32'(oe));
		wr(OFS_COUNTER, 32'h0);
		wr(OFS_GRA, 32'h3);
		// Toggle code: pin starts at the low initial level and flips high on the match
		wr(OFS_IO_CTRL, 32'h3);
		chk("recover_init", 32'h0, 32'(po));
		wr(OFS_RUN_CTRL, 32'h1);
		repeat (10) @(posedge aclk);
		chk("recover_match", 32'h1, 32'(po));
	endtask
	task automatic t_capture();
		logic [31:0] d;
		logic [1:0] r;
		logic [3:0] m[3] = '{4'h8, 4'h9, 4'ha};
		for (int i = 0; i < 3; i++) begin
			lvl <= (i == 0);
			wr(OFS_RUN_CTRL, 32'h0);
			wr(OFS_IO_CTRL, 32'(m[i]));
			chk("capture_oe", 32'h0, 32'(oe));
			// Let the level change at release settle before arming
			repeat (6) @(posedge aclk);
			wr(OFS_GRA, 32'h0);
			wr(OFS_COUNTER, 32'(32'h120 + i));
			lvl <= (i != 0);
			repeat (6) @(posedge aclk);
			rdt(OFS_GRA, d, r);
			chk("first_edge", (i == 2) ? 32'(32'h120 + i) : 32'h0, d);
			lvl <= (i == 0);
			repeat (6) @(posedge aclk);
			rdt(OFS_GRA, d, r);
			chk("second_edge", 32'(32'h120 + i), d);
		end
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_bus();
		t_compare();
		t_capture();
		t_recovery();
		end_of_test();
	end
endmodule
`default_nettype wire
